// File: ntw_consts.vh
// constants for the line wake state control block
`ifndef NTW_CONSTS_VH
`define NTW_CONSTS_VH
// apb register byte offsets
`define NTW_REG_CTRL 8'h00
`define NTW_REG_CMDW 8'h04
`define NTW_REG_STAT 8'h08
`define NTW_REG_TEST 8'h0C
// ctrl fields
`define NTW_CTRL_HOLD 0
`define NTW_CTRL_SOFT 1
`define NTW_CTRL_RST 32'h0000_0000
// command codes from downstream
`define NTW_CMD_TIM 4'h0
`define NTW_CMD_REBOOT 4'h1
`define NTW_CMD_FAULT 4'h4
`define NTW_CMD_SSP 4'h5
`define NTW_CMD_DT 4'h6
`define NTW_CMD_WAKE 4'h8
`define NTW_CMD_LOOPWAKE 4'hA
`define NTW_CMD_LAYERUP 4'hC
`define NTW_CMD_PERMIT 4'hF
// status codes to downstream
`define NTW_IND_DR 4'h0
`define NTW_IND_FAULT 4'h4
`define NTW_IND_PU 4'h7
`define NTW_IND_AR 4'h8
`define NTW_IND_ARL 4'hA
`define NTW_IND_AI 4'hC
`define NTW_IND_AIL 4'hE
`define NTW_IND_DC 4'hF
// line signal selects
`define NTW_SIG_NONE 3'h0
`define NTW_SIG_TONE 3'h1
`define NTW_SIG_ECHO 3'h2
`define NTW_SIG_ONES 3'h3
`define NTW_SIG_USER 3'h4
`define NTW_SIG_PULSE 3'h5
// timer durations in microseconds, tone and pulse rates in hertz, system clock in MHz
`define NTW_T_GUARD_US 15000000
`define NTW_T_RXHOLD_US 40000
`define NTW_T_TONE_US 9000
`define NTW_T_ECHO_US 5500000
`define NTW_T_FSYNC_US 15000000
`define NTW_T_CLKHOLD_US 500
`define NTW_T_SFWAIT_US 10000
`define NTW_TONE_HZ 10000
`define NTW_PULSE_HZ 40000
`define NTW_SPACE_US 1500
`define NTW_CLK_MHZ 250
`endif

// File: ntw_state_ctrl.v
// line wake state control: command decode, state timers, line signal select
`timescale 1ns/1ns
`default_nettype none
`include "ntw_consts.vh"
// Operation
// - hold bit forces quiet test state
// - loop termination pulses force reset/transparent
// - command register write wakes deactivated state once the serial clock is stopped
// - layer up notice sends layer bit 1
// - wakeup request starts wakeup tone
// - loopback wakeup closes loop, echo training
// - teardown permit enters deactivated state
// - through test forces transparent state
// - fault notice sends layer bit 0
// - reboot resets; single pulse starts test
// - clock wake enters clock awake state
// - layer bit one gives transparency
// - teardown bit zero starts deactivation
// - u only bit gates subscriber side
// - guard, receive hold, tone timers
// - echo, frame sync, clock hold, superframe timers
// - fault notice on framing loss, guard expiry
// - line teardown gives teardown request
// - loopback 2 gives loopback indications
// - generate tone, echo, framed line signals
// - four selectable pulse test options
// - four bit command and status codes
// - command valid after two equal frames
// - timers restart on state entry
module ntw_state_ctrl #(
    parameter GUARD_CYC = `NTW_T_GUARD_US * `NTW_CLK_MHZ,
    parameter RXHOLD_CYC = `NTW_T_RXHOLD_US * `NTW_CLK_MHZ,
    parameter TONE_CYC = `NTW_T_TONE_US * `NTW_CLK_MHZ,
    parameter ECHO_CYC = `NTW_T_ECHO_US * `NTW_CLK_MHZ,
    parameter FSYNC_CYC = `NTW_T_FSYNC_US * `NTW_CLK_MHZ,
    parameter CLKHOLD_CYC = `NTW_T_CLKHOLD_US * `NTW_CLK_MHZ,
    parameter SFWAIT_CYC = `NTW_T_SFWAIT_US * `NTW_CLK_MHZ,
    parameter SPACE_CYC = `NTW_SPACE_US * `NTW_CLK_MHZ
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire clk_en_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire frame_strobe_in,
    input wire [3:0] cmd_code_in,
    output reg [3:0] status_code_out,
    input wire layer_up_bit_in,
    input wire teardown_bit_in,
    input wire u_only_bit_in,
    input wire rx_overhead_valid_in,
    input wire tone_detect_in,
    input wire frame_lost_in,
    input wire frame_sync_in,
    input wire superframe_sync_in,
    input wire echo_converged_in,
    input wire loop2_eoc_in,
    input wire serial_clk_run_in,
    input wire loop_term_reset_in,
    input wire loop_term_through_in,
    output reg layer_up_bit_out,
    output reg subscriber_act_out,
    output reg [2:0] line_signal_out,
    output reg line_symbol_valid_out,
    output reg [1:0] line_symbol_out,
    output reg transceiver_reset_out,
    output reg analog_loop_out,
    output reg power_down_out
);
    // states
    localparam S_RESET = 4'h0;
    localparam S_DEACT = 4'h1;
    localparam S_AWAKE = 4'h2;
    localparam S_ALERT = 4'h3;
    localparam S_ECHO = 4'h4;
    localparam S_PRXRST = 4'h5;
    localparam S_SFWAIT = 4'h6;
    localparam S_SYNC = 4'h7;
    localparam S_TRANSP = 4'h8;
    localparam S_PDEACT = 4'h9;
    localparam S_RXRST = 4'hA;
    localparam S_PTIM = 4'hB;
    localparam S_FAULT = 4'hC;
    localparam S_QUIET = 4'hD;
    localparam S_PULSE = 4'hE;
    localparam S_LOOP = 4'hF;
    localparam HALF_TONE = `NTW_CLK_MHZ * 500000 / `NTW_TONE_HZ;
    localparam HALF_PULSE = `NTW_CLK_MHZ * 500000 / `NTW_PULSE_HZ;

    reg [31:0] ctrl_ff;
    reg [1:0] test_ff;
    reg [3:0] cmdw_ff;
    reg cmdw_pend_ff;
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [31:0] tmr_ff;
    reg [31:0] guard_ff;
    reg guard_on_ff;
    reg [3:0] last_cmd_ff;
    reg [3:0] cmd_ff;
    reg from_deact_ff;
    reg loopback_ff;
    reg [31:0] sym_ff;
    reg sym_pol_ff;
    reg [1:0] lt_rst_s_ff;
    reg [1:0] lt_thr_s_ff;
    reg [1:0] act_s_ff;
    reg [1:0] dea_s_ff;
    reg [1:0] uoa_s_ff;
    reg [3:0] ind;
    reg [2:0] sig;
    reg tmr_exp;
    reg [31:0] tmr_load;
    wire apb_wr = psel_in && penable_in && pwrite_in;
    wire apb_rd = psel_in && penable_in && !pwrite_in;
    wire hold_bit = ctrl_ff[`NTW_CTRL_HOLD];
    wire soft_rst = ctrl_ff[`NTW_CTRL_SOFT];
    wire act_rx = act_s_ff[1];
    wire dea_rx = dea_s_ff[1];
    wire uoa_rx = uoa_s_ff[1];
    wire lt_rst = lt_rst_s_ff[1];
    wire lt_thr = lt_thr_s_ff[1];
    wire state_chg = (nxt_state != state_ff);

    // loop termination and line overhead bits cross in from the line side
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            lt_rst_s_ff <= 2'h0;
            lt_thr_s_ff <= 2'h0;
            act_s_ff <= 2'h0;
            dea_s_ff <= 2'h3;
            uoa_s_ff <= 2'h0;
        end
        else if (clk_en_in)
        begin
            lt_rst_s_ff <= {lt_rst_s_ff[0], loop_term_reset_in};
            lt_thr_s_ff <= {lt_thr_s_ff[0], loop_term_through_in};
            if (rx_overhead_valid_in)
            begin
                act_s_ff <= {act_s_ff[0], layer_up_bit_in};
                dea_s_ff <= {dea_s_ff[0], teardown_bit_in};
                uoa_s_ff <= {uoa_s_ff[0], u_only_bit_in};
            end
        end
    end

    // double last look: a new downstream code counts only when two frames agree; a pending register write loads once the serial clock stops
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            last_cmd_ff <= `NTW_CMD_PERMIT;
            cmd_ff <= `NTW_CMD_PERMIT;
        end
        else if (clk_en_in)
        begin
            if (cmdw_pend_ff && !serial_clk_run_in)
                cmd_ff <= cmdw_ff;
            else if (frame_strobe_in)
            begin
                last_cmd_ff <= cmd_code_in;
                if (cmd_code_in == last_cmd_ff)
                    cmd_ff <= cmd_code_in;
            end
        end
    end

    // timer reload per state
    always @*
    begin
        case (nxt_state)
            S_RXRST: tmr_load = RXHOLD_CYC;
            S_ALERT: tmr_load = TONE_CYC;
            S_ECHO: tmr_load = ECHO_CYC;
            S_PRXRST: tmr_load = FSYNC_CYC;
            S_PTIM: tmr_load = CLKHOLD_CYC;
            S_SFWAIT: tmr_load = SFWAIT_CYC;
            default: tmr_load = 32'h0000_0000;
        endcase
    end

    always @*
    begin
        tmr_exp = (tmr_ff == 32'h0000_0001);
    end

    // state transitions
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            S_RESET: if (cmd_ff == `NTW_CMD_PERMIT) nxt_state = S_DEACT;
            S_DEACT:
            begin
                if (cmd_ff == `NTW_CMD_TIM) nxt_state = S_AWAKE;
                else if (cmd_ff == `NTW_CMD_WAKE || tone_detect_in) nxt_state = S_ALERT;
                else if (cmd_ff == `NTW_CMD_LOOPWAKE) nxt_state = S_LOOP;
            end
            S_AWAKE:
            begin
                if (cmd_ff == `NTW_CMD_WAKE || tone_detect_in) nxt_state = S_ALERT;
                else if (cmd_ff == `NTW_CMD_LOOPWAKE) nxt_state = S_LOOP;
                else if (cmd_ff == `NTW_CMD_PERMIT) nxt_state = S_DEACT;
            end
            S_ALERT: if (tmr_exp) nxt_state = S_ECHO;
            S_ECHO: if (echo_converged_in) nxt_state = S_PRXRST; else if (tmr_exp) nxt_state = S_FAULT;
            S_PRXRST: if (frame_sync_in) nxt_state = S_SFWAIT; else if (tmr_exp) nxt_state = S_FAULT;
            S_SFWAIT: if (tmr_exp && superframe_sync_in) nxt_state = S_SYNC;
            S_SYNC: if (act_rx) nxt_state = S_TRANSP;
            S_TRANSP:
            begin
                if (!dea_rx) nxt_state = S_PDEACT;
                else if (frame_lost_in) nxt_state = S_FAULT;
                else if (!act_rx) nxt_state = S_SYNC;
            end
            S_PDEACT:
            begin
                if (dea_rx) nxt_state = S_TRANSP;
                else if (cmd_ff == `NTW_CMD_PERMIT) nxt_state = S_RXRST;
            end
            S_RXRST: if (tmr_exp) nxt_state = S_PTIM;
            S_PTIM: if (tmr_exp) nxt_state = S_DEACT;
            S_FAULT: if (!frame_lost_in && frame_sync_in) nxt_state = S_SYNC;
            S_LOOP: if (cmd_ff != `NTW_CMD_LOOPWAKE) nxt_state = S_RESET;
            S_QUIET: if (!hold_bit) nxt_state = S_RESET;
            S_PULSE: nxt_state = S_PULSE;
            default: nxt_state = S_RESET;
        endcase
        if (state_ff != S_LOOP && guard_on_ff && guard_ff == 32'h0000_0001)
            nxt_state = S_FAULT;
        // unconditional commands win over anything the state asked for
        if (cmd_ff == `NTW_CMD_DT) nxt_state = S_TRANSP;
        else if (cmd_ff == `NTW_CMD_SSP) nxt_state = S_PULSE;
        else if (cmd_ff == `NTW_CMD_REBOOT && state_ff != S_RESET) nxt_state = S_RESET;
        if (lt_rst) nxt_state = S_RESET;
        else if (lt_thr) nxt_state = S_TRANSP;
        if (soft_rst) nxt_state = S_RESET;
        if (hold_bit) nxt_state = S_QUIET;
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_ff <= S_RESET;
            tmr_ff <= 32'h0000_0000;
            guard_ff <= 32'h0000_0000;
            guard_on_ff <= 1'b0;
            from_deact_ff <= 1'b0;
            loopback_ff <= 1'b0;
        end
        else if (clk_en_in)
        begin
            state_ff <= nxt_state;
            if (state_chg)
                tmr_ff <= tmr_load;
            else if (tmr_ff != 32'h0000_0000)
                tmr_ff <= tmr_ff - 32'h0000_0001;
            if (state_chg && nxt_state == S_ALERT)
            begin
                guard_ff <= GUARD_CYC;
                guard_on_ff <= 1'b1;
                from_deact_ff <= (state_ff == S_DEACT);
            end
            else if (nxt_state == S_TRANSP || nxt_state == S_DEACT || nxt_state == S_RESET)
                guard_on_ff <= 1'b0;
            else if (guard_ff != 32'h0000_0000)
                guard_ff <= guard_ff - 32'h0000_0001;
            if (loop2_eoc_in)
                loopback_ff <= 1'b1;
            else if (nxt_state == S_RESET || nxt_state == S_DEACT)
                loopback_ff <= 1'b0;
        end
    end

    // status code and line signal per state
    always @*
    begin
        ind = `NTW_IND_DC;
        sig = `NTW_SIG_NONE;
        case (state_ff)
            S_ALERT:
            begin
                ind = from_deact_ff ? `NTW_IND_PU : `NTW_IND_DC;
                sig = `NTW_SIG_TONE;
            end
            S_ECHO, S_PRXRST: sig = `NTW_SIG_ECHO;
            S_LOOP: sig = `NTW_SIG_ECHO;
            S_SFWAIT: sig = `NTW_SIG_ONES;
            S_SYNC:
            begin
                ind = loopback_ff ? `NTW_IND_ARL : `NTW_IND_AR;
                sig = loopback_ff ? `NTW_SIG_USER : `NTW_SIG_ONES;
            end
            S_TRANSP:
            begin
                ind = loopback_ff ? `NTW_IND_AIL : `NTW_IND_AI;
                sig = `NTW_SIG_USER;
            end
            S_PDEACT: ind = `NTW_IND_DR;
            S_FAULT: ind = `NTW_IND_FAULT;
            S_PULSE: sig = `NTW_SIG_PULSE;
            default: ind = `NTW_IND_DC;
        endcase
    end

    // symbol generator; pulse mode picks rate and amplitude from the test register
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            sym_ff <= 32'h0000_0000;
            sym_pol_ff <= 1'b0;
            line_symbol_valid_out <= 1'b0;
            line_symbol_out <= 2'h0;
        end
        else if (clk_en_in)
        begin
            line_symbol_valid_out <= 1'b0;
            if (sig != `NTW_SIG_TONE && sig != `NTW_SIG_PULSE)
                sym_ff <= 32'h0000_0000;
            else if (sym_ff == 32'h0000_0000)
            begin
                sym_pol_ff <= ~sym_pol_ff;
                line_symbol_valid_out <= 1'b1;
                // bit1 = polarity, bit0 = full amplitude
                line_symbol_out <= {sym_pol_ff, (sig == `NTW_SIG_TONE) | test_ff[0]};
                if (sig == `NTW_SIG_TONE)
                    sym_ff <= HALF_TONE - 1;
                else
                    sym_ff <= test_ff[1] ? SPACE_CYC - 1 : HALF_PULSE - 1;
            end
            else
                sym_ff <= sym_ff - 32'h0000_0001;
        end
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            status_code_out <= `NTW_IND_DC;
            layer_up_bit_out <= 1'b0;
            subscriber_act_out <= 1'b0;
            line_signal_out <= `NTW_SIG_NONE;
            transceiver_reset_out <= 1'b1;
            analog_loop_out <= 1'b0;
            power_down_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            status_code_out <= ind;
            line_signal_out <= sig;
            if (cmd_ff == `NTW_CMD_LAYERUP)
                layer_up_bit_out <= 1'b1;
            else if (cmd_ff == `NTW_CMD_FAULT || state_ff == S_RESET || state_ff == S_DEACT)
                layer_up_bit_out <= 1'b0;
            subscriber_act_out <= uoa_rx && (state_ff == S_TRANSP || state_ff == S_SYNC);
            transceiver_reset_out <= (state_ff == S_QUIET) || (state_ff == S_RESET);
            analog_loop_out <= (state_ff == S_LOOP);
            power_down_out <= (state_ff == S_DEACT) && !serial_clk_run_in;
        end
    end

    // apb slave, zero wait states
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctrl_ff <= `NTW_CTRL_RST;
            test_ff <= 2'h0;
            cmdw_ff <= `NTW_CMD_PERMIT;
            cmdw_pend_ff <= 1'b0;
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            pready_out <= psel_in && !penable_in;
            pslverr_out <= 1'b0;
            // soft reset bit self clears after one cycle of effect
            if (soft_rst)
                ctrl_ff[`NTW_CTRL_SOFT] <= 1'b0;
            if (cmdw_pend_ff && !serial_clk_run_in)
                cmdw_pend_ff <= 1'b0;
            if (psel_in && !penable_in)
            begin
                case (paddr_in)
                    `NTW_REG_CTRL: prdata_out <= {30'h0, ctrl_ff[1:0]};
                    `NTW_REG_CMDW: prdata_out <= {28'h0, cmdw_ff};
                    `NTW_REG_STAT: prdata_out <= {20'h0, status_code_out, state_ff, 1'b0, line_signal_out};
                    `NTW_REG_TEST: prdata_out <= {30'h0, test_ff};
                    default: prdata_out <= 32'h0000_0000;
                endcase
                pslverr_out <= (paddr_in != `NTW_REG_CTRL) && (paddr_in != `NTW_REG_CMDW) &&
                    (paddr_in != `NTW_REG_STAT) && (paddr_in != `NTW_REG_TEST);
            end
            if (apb_wr && pready_out)
            begin
                case (paddr_in)
                    `NTW_REG_CTRL: ctrl_ff <= {30'h0, pwdata_in[1:0]};
                    `NTW_REG_CMDW:
                    begin
                        cmdw_ff <= pwdata_in[3:0];
                        cmdw_pend_ff <= 1'b1;
                    end
                    `NTW_REG_TEST: test_ff <= pwdata_in[1:0];
                    default: test_ff <= test_ff;
                endcase
            end
            if (apb_rd && pready_out)
                prdata_out <= prdata_out;
        end
    end
endmodule
`default_nettype wire

// File: ntw_state_ctrl_props.sv
// concurrent checks on the line wake state control ports
`timescale 1ns/1ns
`default_nettype none
`include "ntw_consts.vh"
module ntw_state_ctrl_props #(
    parameter TONE_CYC = 20
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pready_out,
    input wire frame_strobe_in,
    input wire [3:0] cmd_code_in,
    input wire layer_up_bit_out,
    input wire [2:0] line_signal_out,
    input wire line_symbol_valid_out,
    input wire [1:0] line_symbol_out,
    input wire transceiver_reset_out,
    input wire analog_loop_out,
    input wire loop_term_reset_in
);
    reg [3:0] last_code_ff;
    reg amp_ff;
    reg [31:0] tone_cnt_ff;
    wire wr_done;
    assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            last_code_ff <= 4'h2;
            amp_ff <= 1'b0;
            tone_cnt_ff <= 32'h0;
        end
        else
        begin
            if (frame_strobe_in)
                last_code_ff <= cmd_code_in;
            if (wr_done && paddr_in == `NTW_REG_TEST)
                amp_ff <= pwdata_in[0];
            tone_cnt_ff <= (line_signal_out == `NTW_SIG_TONE) ? tone_cnt_ff + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_cmd(logic [3:0] c);
        frame_strobe_in && cmd_code_in == c && last_code_ff == c;
    endsequence
    property p_hold;
        wr_done && paddr_in == `NTW_REG_CTRL && pwdata_in[0] |-> ##[1:4] transceiver_reset_out;
    endproperty
    property p_reboot;
        s_cmd(`NTW_CMD_REBOOT) |-> ##[1:4] transceiver_reset_out;
    endproperty
    property p_ssp;
        s_cmd(`NTW_CMD_SSP) |-> ##[1:4] line_signal_out == `NTW_SIG_PULSE;
    endproperty
    property p_through;
        s_cmd(`NTW_CMD_DT) ##0 !loop_term_reset_in |-> ##[1:4] !transceiver_reset_out;
    endproperty
    property p_fault;
        s_cmd(`NTW_CMD_FAULT) |-> ##[1:4] !layer_up_bit_out;
    endproperty
    property p_loopwake;
        s_cmd(`NTW_CMD_LOOPWAKE) |-> ##[1:4] analog_loop_out && line_signal_out == `NTW_SIG_ECHO;
    endproperty
    property p_loopterm;
        loop_term_reset_in [*6] |-> transceiver_reset_out;
    endproperty
    property p_tone;
        tone_cnt_ff != 0 && line_signal_out != `NTW_SIG_TONE && !transceiver_reset_out
            |-> tone_cnt_ff + 2 >= TONE_CYC && tone_cnt_ff <= TONE_CYC + 2;
    endproperty
    property p_pulse_amp;
        line_symbol_valid_out && line_signal_out == `NTW_SIG_PULSE |-> line_symbol_out[0] == amp_ff;
    endproperty
    a_hold: assert property (p_hold) else $error("hold bit did not reset transceiver");
    a_reboot: assert property (p_reboot) else $error("reboot code did not reset");
    a_ssp: assert property (p_ssp) else $error("single pulse code gave no pulse signal");
    a_through: assert property (p_through) else $error("through test left reset");
    a_fault: assert property (p_fault) else $error("fault code left layer bit high");
    a_loopwake: assert property (p_loopwake) else $error("loop wake gave no loop");
    a_loopterm: assert property (p_loopterm) else $error("loop termination reset ignored");
    a_tone: assert property (p_tone) else $error("tone length wrong");
    a_pulse_amp: assert property (p_pulse_amp) else $error("pulse amplitude wrong");
endmodule
bind ntw_state_ctrl ntw_state_ctrl_props #(.TONE_CYC(TONE_CYC)) i_props (.*);
`default_nettype wire

// File: ntw_down_model.sv
// downstream device and line side frame source
`timescale 1ns/1ns
`default_nettype none
module ntw_down_model #(
    parameter FRAME = 8
) (
    input wire clk_sys_in,
    input wire rst_in,
    input wire clk_run_in,
    input wire [3:0] code_in,
    input wire [2:0] bits_in,
    output reg frame_strobe_out,
    output reg [3:0] cmd_code_out,
    output reg rx_valid_out,
    output reg [2:0] rx_bits_out
);
    reg [3:0] cnt_ff;
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            cnt_ff <= 4'h0;
            frame_strobe_out <= 1'b0;
            cmd_code_out <= 4'hF;
            rx_valid_out <= 1'b0;
            rx_bits_out <= 3'h7;
        end
        else
        begin
            cnt_ff <= (!clk_run_in || cnt_ff == FRAME - 1) ? 4'h0 : cnt_ff + 4'h1;
            if (clk_run_in && cnt_ff == 4'h0)
                cmd_code_out <= code_in;
            frame_strobe_out <= clk_run_in && cnt_ff == FRAME / 2;
            rx_valid_out <= clk_run_in && cnt_ff == 4'h1;
            if (cnt_ff == 4'h0)
                rx_bits_out <= bits_in;
        end
    end
endmodule
`default_nettype wire

// File: tb_ntw_state_ctrl.sv
// testbench for the line wake state control block
`timescale 1ns/1ns
`default_nettype none
`include "ntw_consts.vh"
module tb_ntw_state_ctrl;
    localparam GUARD = 120;
    localparam TONE = 20;
    localparam SPACE = 40;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] code = 4'hF;
    reg [2:0] bits = 3'h7;
    reg clk_run = 1'b1;
    reg lt_reset = 1'b0;
    reg lt_through = 1'b0;
    reg ce = 1'b1;
    reg [5:0] ev = 6'h0;
    wire [31:0] prdata;
    wire pready, pslverr, strobe, rx_valid, layer_up, sub_act, sym_v, xrst, aloop, pdown;
    wire [3:0] cmd, status;
    wire [2:0] rx_bits, sig;
    wire [1:0] sym;
    reg [31:0] rd;
    reg er;
    integer n_errors = 0;
    integer compares = 0;
    integer cycles = 0;
    integer k;
    ntw_down_model i_down (.clk_sys_in(clk), .rst_in(rst), .clk_run_in(clk_run), .code_in(code),
        .bits_in(bits), .frame_strobe_out(strobe), .cmd_code_out(cmd), .rx_valid_out(rx_valid),
        .rx_bits_out(rx_bits));
    ntw_state_ctrl #(.GUARD_CYC(GUARD), .RXHOLD_CYC(40), .TONE_CYC(TONE), .ECHO_CYC(400), .FSYNC_CYC(400),
        .CLKHOLD_CYC(20), .SFWAIT_CYC(40), .SPACE_CYC(SPACE)) i_dut (
        .clk_sys_in(clk), .rst_in(rst), .clk_en_in(ce), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .frame_strobe_in(strobe), .cmd_code_in(cmd), .status_code_out(status),
        .layer_up_bit_in(rx_bits[0]), .teardown_bit_in(rx_bits[1]), .u_only_bit_in(rx_bits[2]),
        .rx_overhead_valid_in(rx_valid), .tone_detect_in(ev[0]), .frame_lost_in(ev[1]), .frame_sync_in(ev[2]),
        .superframe_sync_in(ev[3]), .echo_converged_in(ev[4]), .loop2_eoc_in(ev[5]), .serial_clk_run_in(clk_run),
        .loop_term_reset_in(lt_reset), .loop_term_through_in(lt_through), .layer_up_bit_out(layer_up),
        .subscriber_act_out(sub_act), .line_signal_out(sig), .line_symbol_valid_out(sym_v),
        .line_symbol_out(sym), .transceiver_reset_out(xrst), .analog_loop_out(aloop), .power_down_out(pdown));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task results;
        begin
            $display("errors %0d compares %0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t run did not finish", $time);
            results;
        end
    end
    task chk(input [31:0] got, input [31:0] exp, input string what);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask
    task done(input string name);
        $display("test %s done", name);
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    task send(input [3:0] c, input integer n);
        begin
            code <= c;
            k = 0;
            while (k < n)
            begin
                @(posedge clk);
                if (strobe === 1'b1)
                    k = k + 1;
            end
            cyc(3);
        end
    endtask
    initial
    begin
        cyc(4);
        rst <= 1'b0;
        @(posedge clk);
        chk(status, 4'hF, "status after reset");
        chk(xrst, 1'b1, "reset after reset");
        apb(1'b0, `NTW_REG_CTRL, 32'h0);
        chk(rd, `NTW_CTRL_RST, "ctrl reset value");
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1'b1, `NTW_REG_TEST, 32'h3);
        apb(1'b0, `NTW_REG_TEST, 32'h0);
        chk(rd, 32'h3, "test register");
        done("registers");
        send(`NTW_CMD_DT, 4);
        chk(xrst, 1'b0, "through test");
        chk(sub_act, 1'b1, "subscriber side");
        send(`NTW_CMD_LAYERUP, 4);
        chk(layer_up, 1'b1, "layer up sent");
        send(`NTW_CMD_FAULT, 4);
        chk(layer_up, 1'b0, "layer up dropped");
        apb(1'b1, `NTW_REG_CTRL, 32'h1);
        cyc(3);
        chk(xrst, 1'b1, "hold bit");
        apb(1'b1, `NTW_REG_CTRL, 32'h0);
        done("through and hold");
        send(`NTW_CMD_REBOOT, 4);
        chk(xrst, 1'b1, "reboot");
        send(`NTW_CMD_SSP, 1);
        send(`NTW_CMD_REBOOT, 4);
        chk(sig == `NTW_SIG_PULSE, 1'b0, "single frame code");
        send(`NTW_CMD_SSP, 4);
        chk(sig, `NTW_SIG_PULSE, "single pulses");
        while (sym_v !== 1'b1)
            @(posedge clk);
        @(posedge clk);
        k = 1;
        while (sym_v !== 1'b1)
        begin
            @(posedge clk);
            k = k + 1;
        end
        chk(k, SPACE, "pulse spacing");
        chk(sym[0], 1'b1, "pulse amplitude");
        done("pulses");
        send(`NTW_CMD_REBOOT, 4);
        send(`NTW_CMD_PERMIT, 4);
        clk_run <= 1'b0;
        cyc(4);
        chk(pdown, 1'b1, "power down");
        code <= `NTW_CMD_WAKE;
        apb(1'b1, `NTW_REG_CMDW, {28'h0, `NTW_CMD_WAKE});
        cyc(3);
        chk(sig, `NTW_SIG_TONE, "register wake");
        clk_run <= 1'b1;
        cyc(TONE + 4);
        chk(sig, `NTW_SIG_ECHO, "tone then echo training");
        cyc(GUARD - TONE - 24);
        chk(status == `NTW_IND_FAULT, 1'b0, "no fault before guard");
        cyc(28);
        chk(status, `NTW_IND_FAULT, "guard expiry");
        done("wake and guard");
        send(`NTW_CMD_REBOOT, 4);
        send(`NTW_CMD_PERMIT, 4);
        send(`NTW_CMD_WAKE, 3);
        chk(sig, `NTW_SIG_TONE, "downstream wake");
        send(`NTW_CMD_REBOOT, 4);
        send(`NTW_CMD_PERMIT, 4);
        send(`NTW_CMD_LOOPWAKE, 4);
        chk({aloop, sig}, {1'b1, `NTW_SIG_ECHO}, "analog loop");
        done("loop wake");
        send(`NTW_CMD_REBOOT, 4);
        send(`NTW_CMD_LAYERUP, 2);
        lt_through <= 1'b1;
        cyc(8);
        chk(xrst, 1'b0, "loop termination through");
        lt_through <= 1'b0;
        send(`NTW_CMD_DT, 4);
        lt_reset <= 1'b1;
        cyc(8);
        chk(xrst, 1'b1, "loop termination reset");
        lt_reset <= 1'b0;
        done("loop termination");
        results;
    end
endmodule
`default_nettype wire
